// >>> mwc_pkg.sv
package mwc_pkg;
	// Storage sizes
	localparam int MEM_BYTES = 1450;
	localparam int MAX_WORDS = 64;
	localparam int NAME_MAX = 31;
	localparam int CMD_MAX = 128;
	localparam int OPT_MAX = 8;
	localparam int OPT_BYTES = 64;
	// Sized limits derived from the sizes above
	localparam logic [10:0] MEM_LIMIT = 11'(MEM_BYTES);
	localparam logic [6:0] WORD_LIMIT = 7'(MAX_WORDS);
	localparam logic [5:0] NAME_LIMIT = 6'(NAME_MAX);
	localparam logic [7:0] CMD_LIMIT = 8'(CMD_MAX);
	localparam logic [3:0] OPT_LIMIT = 4'(OPT_MAX);
	localparam logic [6:0] OPT_BYTE_LIMIT = 7'(OPT_BYTES);
	// Reset value of the macro error status bit
	localparam logic ERR_RESET = 1'b0;
	// Characters with a meaning of their own
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_WILD = 8'h24;
	// Fixed response text: list tags, state keywords, reserved list
	localparam logic [7:0] FIX_ROM [0:42] = '{
		8'h55, 8'h4e, 8'h4c, 8'h55, 8'h54, 8'h4c, 8'h4e, 8'h45, 8'h57,
		8'h4f, 8'h4c, 8'h44, 8'h52, 8'h4e, 8'h4c, 8'h20, 8'h41, 8'h4c,
		8'h49, 8'h41, 8'h53, 8'h20, 8'h4e, 8'h45, 8'h57, 8'h20, 8'h4f,
		8'h4c, 8'h44, 8'h20, 8'h4c, 8'h49, 8'h53, 8'h54, 8'h20, 8'h46,
		8'h4f, 8'h52, 8'h47, 8'h45, 8'h54, 8'h20, 8'h24};
	localparam logic [5:0] ROM_NAME_TAG_LO = 6'h00;
	localparam logic [5:0] ROM_NAME_TAG_HI = 6'h02;
	localparam logic [5:0] ROM_TRANS_TAG_LO = 6'h03;
	localparam logic [5:0] ROM_TRANS_TAG_HI = 6'h05;
	localparam logic [5:0] ROM_ENABLED_LO = 6'h06;
	localparam logic [5:0] ROM_ENABLED_HI = 6'h08;
	localparam logic [5:0] ROM_DISABLED_LO = 6'h09;
	localparam logic [5:0] ROM_DISABLED_HI = 6'h0b;
	localparam logic [5:0] ROM_RESERVED_LO = 6'h0c;
	localparam logic [5:0] ROM_RESERVED_HI = 6'h2a;

	typedef logic [10:0] mwc_addr_t;
	typedef enum logic [2:0] {CMD_WORD_LIST, CMD_PURGE_WORDS,
		QRY_NAME_LIST, QRY_UNUSED, QRY_RESERVED_LIST,
		QRY_TRANSLATE_STATE, QRY_TRANSLATION_LIST} mwc_cmd_t;
	typedef enum logic [1:0] {K_NAMES, K_TRANS, K_RES, K_STATE} mwc_kind_t;
	typedef enum logic [2:0] {RS_IDLE, RS_WAIT, RS_FIX, RS_SP, RS_NAME,
		RS_SP2, RS_CMD, RS_TERM} mwc_rsp_t;
	typedef enum logic [1:0] {SB_IDLE, SB_OPTS, SB_SCAN, SB_EMIT} mwc_sub_t;

	// Byte address plus an offset, kept to the address width
	function automatic mwc_addr_t mwc_addr_add(input mwc_addr_t base,
		input logic [7:0] off);
		mwc_addr_add = base + {3'h0, off};
	endfunction : mwc_addr_add
endpackage : mwc_pkg

// >>> mwc_word_store.sv
module mwc_word_store
	import mwc_pkg::*;
(
	// Clock and control
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic clear_i,
	// Definition stream
	input wire logic def_valid_i,
	input wire logic [7:0] def_byte_i,
	input wire logic def_is_cmd_i,
	input wire logic def_end_i,
	output logic err_o,
	// Word tables
	output logic [6:0] count_o,
	output logic [MAX_WORDS-1:0][10:0] base_tab_o,
	output logic [MAX_WORDS-1:0][4:0] nlen_tab_o,
	output logic [MAX_WORDS-1:0][7:0] clen_tab_o,
	// Two read ports
	input wire mwc_addr_t a_addr_i,
	output logic [7:0] a_byte_o,
	input wire mwc_addr_t b_addr_i,
	output logic [7:0] b_byte_o
);
	typedef struct packed {
		logic [MAX_WORDS-1:0][10:0] base;
		logic [MAX_WORDS-1:0][4:0] nlen;
		logic [MAX_WORDS-1:0][7:0] clen;
		logic [6:0] count;
		mwc_addr_t commit;
		logic [5:0] cur_n;
		logic [7:0] cur_c;
		logic bad;
		logic err;
	} mwc_store_t;

	mwc_store_t s_ff;
	mwc_store_t nxt_s;
	logic [7:0] mem [MEM_BYTES];
	mwc_addr_t wr_addr;
	logic wr_en;

	// Entry layout: name bytes then command bytes, packed back to back
	assign wr_addr = mwc_addr_add(mwc_addr_add(s_ff.commit,
		{2'h0, s_ff.cur_n}), s_ff.cur_c);

	// Definition bookkeeping; a failed entry is dropped at its end
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.err = 1'b0;
		wr_en = 1'b0;
		if (clear_i)
		begin
			nxt_s.count = 7'h00;
			nxt_s.commit = 11'h000;
			nxt_s.cur_n = 6'h00;
			nxt_s.cur_c = 8'h00;
			nxt_s.bad = 1'b0;
		end
		else if (def_valid_i)
		begin
			if (wr_addr >= MEM_LIMIT)
				nxt_s.bad = 1'b1;
			else if (!def_is_cmd_i && (s_ff.cur_n == NAME_LIMIT
				|| s_ff.cur_c != 8'h00))
				nxt_s.bad = 1'b1;
			else if (def_is_cmd_i && s_ff.cur_c == CMD_LIMIT)
				nxt_s.bad = 1'b1;
			else
			begin
				wr_en = !s_ff.bad;
				if (def_is_cmd_i)
					nxt_s.cur_c = s_ff.cur_c + 8'h01;
				else
					nxt_s.cur_n = s_ff.cur_n + 6'h01;
			end
		end
		else if (def_end_i)
		begin
			if (!s_ff.bad && s_ff.cur_n != 6'h00 && s_ff.cur_c != 8'h00
				&& s_ff.count != WORD_LIMIT)
			begin
				nxt_s.base[s_ff.count[5:0]] = s_ff.commit;
				nxt_s.nlen[s_ff.count[5:0]] = s_ff.cur_n[4:0];
				nxt_s.clen[s_ff.count[5:0]] = s_ff.cur_c;
				nxt_s.count = s_ff.count + 7'h01;
				nxt_s.commit = wr_addr;
			end
			else
				nxt_s.err = 1'b1;
			nxt_s.cur_n = 6'h00;
			nxt_s.cur_c = 8'h00;
			nxt_s.bad = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			s_ff <= '0;
		else if (ce_i)
			s_ff <= nxt_s;
	end

	// Byte array is not cleared; the tables alone say what is valid
	always_ff @(posedge clk_i)
	begin
		if (ce_i && wr_en)
			mem[wr_addr] <= def_byte_i;
	end

	assign a_byte_o = mem[a_addr_i];
	assign b_byte_o = mem[b_addr_i];
	assign err_o = s_ff.err;
	assign count_o = s_ff.count;
	assign base_tab_o = s_ff.base;
	assign nlen_tab_o = s_ff.nlen;
	assign clen_tab_o = s_ff.clen;
endmodule : mwc_word_store

// >>> mwc_subst.sv
module mwc_subst
	import mwc_pkg::*;
(
	// Clock and control
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic clear_i,
	// Invocation
	input wire logic start_i,
	input wire mwc_addr_t cmd_base_i,
	input wire logic [7:0] cmd_len_i,
	input wire logic opt_valid_i,
	input wire logic [7:0] opt_byte_i,
	input wire logic opt_next_i,
	input wire logic opt_end_i,
	// Stored command read
	output mwc_addr_t mem_addr_o,
	input wire logic [7:0] mem_byte_i,
	// Executed command stream
	output logic exec_valid_o,
	output logic [7:0] exec_byte_o,
	output logic exec_last_o,
	input wire logic exec_ready_i,
	output logic err_o
);
	typedef struct packed {
		mwc_sub_t state;
		mwc_addr_t base;
		logic [7:0] clen;
		logic [7:0] pos;
		logic [3:0] wild;
		logic [3:0] nopt;
		logic [OPT_MAX:0][6:0] starts;
		logic [6:0] wp;
		logic [6:0] rp;
		logic [3:0] cur;
		logic in_opt;
		logic ovf;
		logic valid;
		logic [7:0] data;
		logic last;
		logic err;
	} mwc_sub_st_t;

	mwc_sub_st_t s_ff;
	mwc_sub_st_t nxt_s;
	logic [7:0] opt_buf [OPT_BYTES];
	logic buf_we;
	logic can;

	assign mem_addr_o = mwc_addr_add(s_ff.base, s_ff.pos);
	assign can = !s_ff.valid || exec_ready_i;

	// Options are gathered first, then the command is scanned and sent
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.err = 1'b0;
		buf_we = 1'b0;
		if (s_ff.valid && exec_ready_i)
			nxt_s.valid = 1'b0;
		unique case (s_ff.state)
			SB_IDLE:
				if (start_i)
				begin
					nxt_s = '0;
					nxt_s.state = SB_OPTS;
					nxt_s.base = cmd_base_i;
					nxt_s.clen = cmd_len_i;
				end
			SB_OPTS:
			begin
				if (opt_valid_i && s_ff.nopt != OPT_LIMIT)
				begin
					buf_we = s_ff.wp != OPT_BYTE_LIMIT;
					nxt_s.ovf = s_ff.ovf | !buf_we;
					nxt_s.wp = s_ff.wp + {6'h00, buf_we};
				end
				// Empty options are not counted, so doubled spaces are harmless
				if ((opt_next_i || opt_end_i) && s_ff.nopt != OPT_LIMIT
					&& s_ff.wp != s_ff.starts[s_ff.nopt])
				begin
					nxt_s.starts[s_ff.nopt + 4'h1] = s_ff.wp;
					nxt_s.nopt = s_ff.nopt + 4'h1;
				end
				if (opt_end_i)
					nxt_s.state = SB_SCAN;
			end
			SB_SCAN:
			begin
				if (mem_byte_i == CH_WILD)
					nxt_s.wild = s_ff.wild + 4'h1;
				nxt_s.pos = s_ff.pos + 8'h01;
				if (s_ff.pos == s_ff.clen - 8'h01)
				begin
					nxt_s.pos = 8'h00;
					nxt_s.state = SB_EMIT;
					if (nxt_s.wild > s_ff.nopt || s_ff.ovf)
					begin
						nxt_s.err = 1'b1;
						nxt_s.state = SB_IDLE;
					end
				end
			end
			SB_EMIT:
				if (s_ff.valid && s_ff.last && exec_ready_i)
					nxt_s.state = SB_IDLE;
				else if (can && !(s_ff.valid && s_ff.last))
				begin
					if (s_ff.in_opt)
					begin
						// Option value replaces the wildcard in place
						nxt_s.valid = 1'b1;
						nxt_s.data = opt_buf[s_ff.rp[5:0]];
						nxt_s.rp = s_ff.rp + 7'h01;
						if (s_ff.rp + 7'h01 == s_ff.starts[s_ff.cur + 4'h1])
						begin
							nxt_s.in_opt = 1'b0;
							nxt_s.cur = s_ff.cur + 4'h1;
							nxt_s.last = s_ff.pos == s_ff.clen;
						end
					end
					else if (mem_byte_i == CH_WILD)
					begin
						nxt_s.in_opt = 1'b1;
						nxt_s.rp = s_ff.starts[s_ff.cur];
						nxt_s.pos = s_ff.pos + 8'h01;
					end
					else
					begin
						nxt_s.valid = 1'b1; // Fixed bytes kept
						nxt_s.data = mem_byte_i;
						nxt_s.pos = s_ff.pos + 8'h01;
						nxt_s.last = s_ff.pos + 8'h01 == s_ff.clen;
					end
				end
		endcase
		if (clear_i)
		begin
			nxt_s.state = SB_IDLE;
			nxt_s.valid = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			s_ff <= '0;
		else if (ce_i)
			s_ff <= nxt_s;
	end

	always_ff @(posedge clk_i)
	begin
		if (ce_i && buf_we)
			opt_buf[s_ff.wp[5:0]] <= opt_byte_i;
	end

	assign exec_valid_o = s_ff.valid;
	assign exec_byte_o = s_ff.data;
	assign exec_last_o = s_ff.last;
	assign err_o = s_ff.err;
endmodule : mwc_subst

// >>> mwc_macro_word_interp.sv
// Behaviour
// - Word list sent newest first, space separated
// - No stored words gives no words
// - Word list omits the command strings
// - Terminator with end flag after word list
// - Purge command erases every stored word
// - Bus clear commands also erase words
// - Name list query equals word list command
// - Reserved list query sends tag and keywords
// - State query sends enable or disable keyword
// - Translation list sends names with commands
// - Each answer is sent once per query
// - Every status answer ends terminator plus end
// - Name list starts with its tag unless no words are stored
// - Dollar in stored command marks wildcard
// - Wildcards and fixed options may mix
// - Execute command with wildcards replaced
// - Options fill wildcards in stored order
// - Any macro error sets error status bit
// - Names over 31 characters are refused
module mwc_macro_word_interp
	import mwc_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Decoded commands and bus clears
	input wire logic cmd_valid_i,
	input wire mwc_cmd_t cmd_code_i,
	input wire logic dcl_i,
	input wire logic sdc_i,
	// Device settings kept elsewhere
	input wire logic xlat_enabled_i,
	input wire logic [7:0] term_byte_i,
	// Word definition stream
	input wire logic def_valid_i,
	input wire logic [7:0] def_byte_i,
	input wire logic def_is_cmd_i,
	input wire logic def_end_i,
	// Word invocation and option values
	input wire logic inv_start_i,
	input wire logic [5:0] inv_word_i,
	input wire logic opt_valid_i,
	input wire logic [7:0] opt_byte_i,
	input wire logic opt_next_i,
	input wire logic opt_end_i,
	// Talker byte stream
	input wire logic talk_i,
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output logic [7:0] tx_byte_o,
	output logic tx_eoi_o,
	// Command execution stream
	input wire logic exec_ready_i,
	output logic exec_valid_o,
	output logic [7:0] exec_byte_o,
	output logic exec_last_o,
	// Error status
	input wire logic err_clear_i,
	output logic macro_err_o
);
	typedef struct packed {
		mwc_rsp_t state;
		mwc_kind_t kind;
		logic [5:0] ptr;
		logic [5:0] rom_end;
		logic [5:0] widx;
		logic [7:0] pos;
		logic tx_valid;
		logic [7:0] tx_byte;
		logic tx_eoi;
		logic err;
	} mwc_top_t;

	mwc_top_t s_ff;
	mwc_top_t nxt_s;

	// Store and substitution links
	logic clear;
	logic store_err;
	logic sub_err;
	logic [6:0] count;
	logic [MAX_WORDS-1:0][10:0] base_tab;
	logic [MAX_WORDS-1:0][4:0] nlen_tab;
	logic [MAX_WORDS-1:0][7:0] clen_tab;
	mwc_addr_t a_addr;
	logic [7:0] a_byte;
	mwc_addr_t b_addr;
	logic [7:0] b_byte;
	logic inv_ok;
	logic inv_bad;
	mwc_addr_t inv_base;

	// Word currently sent by the talker
	mwc_addr_t cur_base;
	logic [7:0] cur_nlen;
	logic [7:0] cur_clen;
	logic can;
	logic emit;
	logic [7:0] emit_byte;
	logic emit_eoi;
	logic next_word;

	// Purge and both bus clears drop every word
	assign clear = dcl_i || sdc_i
		|| (cmd_valid_i && cmd_code_i == CMD_PURGE_WORDS);

	// Invocation index must name a stored word
	assign inv_ok = {1'b0, inv_word_i} < count;
	assign inv_bad = inv_start_i && !inv_ok;
	assign inv_base = mwc_addr_add(base_tab[inv_word_i],
		{3'h0, nlen_tab[inv_word_i]});

	assign cur_base = base_tab[s_ff.widx];
	assign cur_nlen = {3'h0, nlen_tab[s_ff.widx]};
	assign cur_clen = clen_tab[s_ff.widx];
	// Name bytes lead the entry, command bytes follow it
	assign a_addr = (s_ff.state == RS_CMD)
		? mwc_addr_add(mwc_addr_add(cur_base, cur_nlen), s_ff.pos)
		: mwc_addr_add(cur_base, s_ff.pos);
	// A byte leaves only while addressed to talk and the slot is free
	assign can = talk_i && (!s_ff.tx_valid || tx_ready_i);

	mwc_word_store u_store (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.clear_i(clear),
		.def_valid_i(def_valid_i),
		.def_byte_i(def_byte_i),
		.def_is_cmd_i(def_is_cmd_i),
		.def_end_i(def_end_i),
		.err_o(store_err),
		.count_o(count),
		.base_tab_o(base_tab),
		.nlen_tab_o(nlen_tab),
		.clen_tab_o(clen_tab),
		.a_addr_i(a_addr),
		.a_byte_o(a_byte),
		.b_addr_i(b_addr),
		.b_byte_o(b_byte)
	);

	mwc_subst u_subst (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.clear_i(clear),
		.start_i(inv_start_i && inv_ok),
		.cmd_base_i(inv_base),
		.cmd_len_i(clen_tab[inv_word_i]),
		.opt_valid_i(opt_valid_i),
		.opt_byte_i(opt_byte_i),
		.opt_next_i(opt_next_i),
		.opt_end_i(opt_end_i),
		.mem_addr_o(b_addr),
		.mem_byte_i(b_byte),
		.exec_valid_o(exec_valid_o),
		.exec_byte_o(exec_byte_o),
		.exec_last_o(exec_last_o),
		.exec_ready_i(exec_ready_i),
		.err_o(sub_err)
	);

	// Talker sequencer: tag, words, then terminator
	always_comb
	begin
		nxt_s = s_ff;
		emit = 1'b0;
		emit_byte = 8'h00;
		emit_eoi = 1'b0;
		next_word = 1'b0;
		if (s_ff.tx_valid && tx_ready_i)
		begin
			nxt_s.tx_valid = 1'b0;
			nxt_s.tx_eoi = 1'b0;
		end
		unique case (s_ff.state)
			RS_IDLE:
				nxt_s.state = RS_IDLE;
			RS_WAIT:
				if (talk_i)
				begin
					nxt_s.state = RS_FIX;
					unique case (s_ff.kind)
						K_NAMES:
						begin
							nxt_s.ptr = ROM_NAME_TAG_LO;
							nxt_s.rom_end = ROM_NAME_TAG_HI;
						end
						K_TRANS:
						begin
							nxt_s.ptr = ROM_TRANS_TAG_LO;
							nxt_s.rom_end = ROM_TRANS_TAG_HI;
						end
						K_RES:
						begin
							nxt_s.ptr = ROM_RESERVED_LO;
							nxt_s.rom_end = ROM_RESERVED_HI;
						end
						K_STATE:
						begin
							// Keyword in the three-character state field
							nxt_s.ptr = xlat_enabled_i ? ROM_ENABLED_LO
								: ROM_DISABLED_LO;
							nxt_s.rom_end = xlat_enabled_i ? ROM_ENABLED_HI
								: ROM_DISABLED_HI;
						end
					endcase
					// With nothing stored only the terminator goes
					if ((s_ff.kind == K_NAMES || s_ff.kind == K_TRANS)
						&& count == 7'h00)
						nxt_s.state = RS_TERM;
				end
			RS_FIX:
				if (can)
				begin
					emit = 1'b1;
					emit_byte = FIX_ROM[s_ff.ptr];
					nxt_s.ptr = s_ff.ptr + 6'h01;
					if (s_ff.ptr == s_ff.rom_end)
					begin
						nxt_s.state = RS_TERM;
						if (s_ff.kind == K_NAMES || s_ff.kind == K_TRANS)
						begin
							// Newest word is the last one stored
							nxt_s.widx = 6'(count - 7'h01);
							nxt_s.state = RS_SP;
						end
					end
				end
			RS_SP:
				if (can)
				begin
					emit = 1'b1; // Words delimited by spaces
					emit_byte = CH_SPACE;
					nxt_s.pos = 8'h00;
					nxt_s.state = RS_NAME;
				end
			RS_NAME:
				if (can)
				begin
					emit = 1'b1;
					emit_byte = a_byte;
					nxt_s.pos = s_ff.pos + 8'h01;
					if (s_ff.pos == cur_nlen - 8'h01)
					begin
						// Name list stops here; no command bytes
						if (s_ff.kind == K_TRANS)
							nxt_s.state = RS_SP2;
						else
							next_word = 1'b1;
					end
				end
			RS_SP2:
				if (can)
				begin
					emit = 1'b1;
					emit_byte = CH_SPACE;
					nxt_s.pos = 8'h00;
					nxt_s.state = RS_CMD;
				end
			RS_CMD:
				if (can)
				begin
					emit = 1'b1; // Command string follows its name
					emit_byte = a_byte;
					nxt_s.pos = s_ff.pos + 8'h01;
					if (s_ff.pos == cur_clen - 8'h01)
						next_word = 1'b1;
				end
			RS_TERM:
				if (can)
				begin
					// Programmed terminator carries the end flag
					emit = 1'b1;
					emit_byte = term_byte_i;
					emit_eoi = 1'b1;
					nxt_s.state = RS_IDLE; // Not repeated on next talk
				end
		endcase

		// Walk toward older words, oldest last
		if (next_word)
		begin
			if (s_ff.widx == 6'h00)
				nxt_s.state = RS_TERM;
			else
			begin
				nxt_s.widx = s_ff.widx - 6'h01;
				nxt_s.state = RS_SP;
			end
		end
		if (emit)
		begin
			nxt_s.tx_valid = 1'b1;
			nxt_s.tx_byte = emit_byte;
			nxt_s.tx_eoi = emit_eoi;
		end

		// A new command abandons any answer still pending
		if (cmd_valid_i)
		begin
			nxt_s.tx_valid = 1'b0;
			nxt_s.tx_eoi = 1'b0;
			nxt_s.state = RS_WAIT;
			unique case (cmd_code_i)
				CMD_WORD_LIST, QRY_NAME_LIST:
					nxt_s.kind = K_NAMES; // Same answer for both
				QRY_TRANSLATION_LIST:
					nxt_s.kind = K_TRANS;
				QRY_RESERVED_LIST:
					nxt_s.kind = K_RES;
				QRY_TRANSLATE_STATE:
					nxt_s.kind = K_STATE;
				QRY_UNUSED, CMD_PURGE_WORDS:
					nxt_s.state = RS_IDLE;
				default:
					nxt_s.state = RS_IDLE;
			endcase
		end
		if (dcl_i || sdc_i)
		begin
			nxt_s.state = RS_IDLE;
			nxt_s.tx_valid = 1'b0;
			nxt_s.tx_eoi = 1'b0;
		end

		// Error bit: a new error wins over a clear in the same cycle
		if (err_clear_i)
			nxt_s.err = ERR_RESET;
		if (store_err || sub_err || inv_bad)
			nxt_s.err = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			s_ff <= '0;
		else if (ce_i)
			s_ff <= nxt_s;
	end

	assign tx_valid_o = s_ff.tx_valid;
	assign tx_byte_o = s_ff.tx_byte;
	assign tx_eoi_o = s_ff.tx_eoi;
	assign macro_err_o = s_ff.err;
endmodule : mwc_macro_word_interp

// >>> mwc_asserts.sv
module mwc_asserts
	import mwc_pkg::*;
(
	// Clock and control
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic cmd_valid_i,
	input wire mwc_cmd_t cmd_code_i,
	input wire logic dcl_i,
	input wire logic sdc_i,
	input wire logic [7:0] term_byte_i,
	input wire logic err_clear_i,
	// Watched streams
	input wire logic tx_ready_i,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_byte_o,
	input wire logic tx_eoi_o,
	input wire logic exec_valid_o,
	input wire logic [7:0] exec_byte_o,
	input wire logic macro_err_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic armed_ff;
	// Armed by a taken command, disarmed once the end byte is taken
	always_ff @(posedge clk_i)
		if (reset_i)
			armed_ff <= 1'b0;
		else if (ce_i && cmd_valid_i)
			armed_ff <= 1'b1;
		else if (ce_i && tx_valid_o && tx_ready_i && tx_eoi_o)
			armed_ff <= 1'b0;
	property p_term;
		tx_eoi_o |-> tx_valid_o && tx_byte_o == term_byte_i;
	endproperty
	a_term: assert property (p_term)
		else $error("end flag without terminator");
	property p_hold;
		tx_valid_o && !tx_ready_i && !cmd_valid_i && !dcl_i && !sdc_i
			|=> tx_valid_o && $stable(tx_byte_o) && $stable(tx_eoi_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("answer byte dropped before taken");
	property p_once;
		tx_valid_o |-> armed_ff;
	endproperty
	a_once: assert property (p_once)
		else $error("answer byte without a new query");
	property p_gap;
		ce_i && cmd_valid_i |=> !tx_valid_o;
	endproperty
	a_gap: assert property (p_gap)
		else $error("answer byte in cycle after command");
	property p_unused;
		ce_i && cmd_valid_i && cmd_code_i == QRY_UNUSED |=> !tx_valid_o [*8];
	endproperty
	a_unused: assert property (p_unused)
		else $error("unused query answered");
	property p_clear;
		ce_i && (dcl_i || sdc_i || cmd_valid_i && cmd_code_i == CMD_PURGE_WORDS)
			|=> !tx_valid_o [*2];
	endproperty
	a_clear: assert property (p_clear)
		else $error("answer byte right after clear");
	property p_nowild;
		exec_valid_o |-> exec_byte_o != CH_WILD;
	endproperty
	a_nowild: assert property (p_nowild)
		else $error("wildcard sent to execution");
	property p_sticky;
		macro_err_o && !err_clear_i |=> macro_err_o;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("error bit lost without clear");
	// Main scenarios reached
	c_answer: cover property (tx_valid_o && tx_ready_i && tx_eoi_o);
	c_exec: cover property (exec_valid_o);
	c_err: cover property ($rose(macro_err_o));
endmodule : mwc_asserts

bind mwc_macro_word_interp mwc_asserts i_mwc_asserts (.clk_i, .reset_i,
	.ce_i, .cmd_valid_i, .cmd_code_i, .dcl_i, .sdc_i, .term_byte_i,
	.err_clear_i, .tx_ready_i, .tx_valid_o, .tx_byte_o, .tx_eoi_o,
	.exec_valid_o, .exec_byte_o, .macro_err_o);

// >>> mwc_bus_ctrl.sv
module mwc_bus_ctrl
(
	// Clock and bench control
	input wire logic clk_i,
	input wire logic talk_en_i,
	input wire logic slow_i,
	// Listener side
	output logic talk_o,
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ph = 1'b0;
	// Addressed to talk only after the bench has sent its query
	assign talk_o = talk_en_i;
	// A slow controller is ready only every other cycle; follows talk at once
	assign tx_ready_o = talk_en_i && (!slow_i || ph);
	always @(negedge clk_i)
		ph <= !ph;
endmodule : mwc_bus_ctrl

// >>> mwc_tb.sv
module tb;
	import mwc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, err_clear_i = 1'b0;
	logic cmd_valid_i = 1'b0, dcl_i = 1'b0, sdc_i = 1'b0, talk_en = 1'b0;
	logic xlat_enabled_i = 1'b0, def_valid_i = 1'b0, def_is_cmd_i = 1'b0;
	logic def_end_i = 1'b0, inv_start_i = 1'b0, opt_valid_i = 1'b0;
	logic opt_next_i = 1'b0, opt_end_i = 1'b0, exec_ready_i = 1'b1;
	logic slow = 1'b0, talk_i, tx_ready_i, tx_valid_o, tx_eoi_o;
	logic exec_valid_o, exec_last_o, macro_err_o;
	logic [7:0] term_byte_i = 8'h0a, def_byte_i = 8'h00, opt_byte_i = 8'h00;
	logic [7:0] tx_byte_o, exec_byte_o;
	logic [5:0] inv_word_i = 6'h00;
	mwc_cmd_t cmd_code_i = CMD_WORD_LIST;
	int errors = 0, checks_done = 0, cyc = 0, seed = 32'h521c249f;
	string names[$], cmds[$], rx = "", ex = "", d;
	mwc_macro_word_interp i_mwc_macro_word_interp (.clk_i, .reset_i, .ce_i,
		.cmd_valid_i, .cmd_code_i, .dcl_i, .sdc_i, .xlat_enabled_i,
		.term_byte_i, .def_valid_i, .def_byte_i, .def_is_cmd_i, .def_end_i,
		.inv_start_i, .inv_word_i, .opt_valid_i, .opt_byte_i, .opt_next_i,
		.opt_end_i, .talk_i, .tx_ready_i, .tx_valid_o, .tx_byte_o, .tx_eoi_o,
		.exec_ready_i, .exec_valid_o, .exec_byte_o, .exec_last_o,
		.err_clear_i, .macro_err_o);
	mwc_bus_ctrl i_mwc_bus_ctrl (.clk_i, .talk_en_i(talk_en), .slow_i(slow),
		.talk_o(talk_i), .tx_ready_o(tx_ready_i));
	always #4 clk_i = !clk_i;
	// Cut a hang short
	always @(posedge clk_i)
		if (++cyc == 20000)
		begin
			errors++;
			tally_and_finish();
		end
	// Random back-pressure on the command stream
	always @(negedge clk_i)
		exec_ready_i <= 1'($random(seed));
	// Record taken bytes; a bar marks the flagged final byte
	always @(posedge clk_i)
	begin
		if (tx_valid_o === 1'b1 && tx_ready_i)
			rx = {rx, string'(tx_byte_o), tx_eoi_o === 1'b1 ? "|" : ""};
		if (exec_valid_o === 1'b1 && exec_ready_i)
			ex = {ex, string'(exec_byte_o), exec_last_o === 1'b1 ? "|" : ""};
	end
	task automatic cmp(string what, string exp, string got);
		checks_done++;
		if (exp != got)
		begin
			errors++;
			$display("unexpected %s: expected %s seen %s", what, exp, got);
		end
	endtask : cmp
	task automatic cmp_bit(string what, logic exp, logic got);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask : cmp_bit
	function automatic string rom(logic [5:0] lo, logic [5:0] hi);
		string s = "";
		for (int i = lo; i <= hi; i++)
			s = {s, string'(FIX_ROM[i])};
		return s;
	endfunction : rom
	function automatic string rstr(int n);
		string s = "";
		repeat (n) s = {s, string'(8'h41 + 8'($unsigned($random(seed)) % 23))};
		return s;
	endfunction : rstr
	// Answer text for each command, newest word first
	function automatic string answer_for(mwc_cmd_t c);
		string s = "";
		logic t = c == QRY_TRANSLATION_LIST;
		case (c)
			QRY_UNUSED, CMD_PURGE_WORDS: return "";
			QRY_RESERVED_LIST: s = rom(ROM_RESERVED_LO, ROM_RESERVED_HI);
			QRY_TRANSLATE_STATE: s = xlat_enabled_i ?
				rom(ROM_ENABLED_LO, ROM_ENABLED_HI) :
				rom(ROM_DISABLED_LO, ROM_DISABLED_HI);
			default:
			begin
				for (int i = names.size() - 1; i >= 0; i--)
					s = {s, " ", names[i], t ? {" ", cmds[i]} : ""};
				if (names.size() > 0)
					s = {t ? rom(ROM_TRANS_TAG_LO, ROM_TRANS_TAG_HI) :
						rom(ROM_NAME_TAG_LO, ROM_NAME_TAG_HI), s};
			end
		endcase
		return {s, string'(term_byte_i), "|"};
	endfunction : answer_for
	task automatic define(string nm, string cm);
		string s = {nm, cm};
		for (int k = 0; k < s.len(); k++)
		begin
			@(negedge clk_i);
			def_valid_i = 1'b1;
			def_byte_i = s[k];
			def_is_cmd_i = k >= nm.len();
		end
		@(negedge clk_i);
		def_valid_i = 1'b0;
		def_end_i = 1'b1; // End pulse closes the definition
		@(negedge clk_i);
		def_end_i = 1'b0;
		repeat (2) @(negedge clk_i);
		cmp_bit("name error", nm.len() > NAME_MAX, macro_err_o);
		err_clear_i = 1'b1;
		@(negedge clk_i);
		err_clear_i = 1'b0;
		if (nm.len() <= NAME_MAX)
		begin
			names.push_back(nm);
			cmds.push_back(cm);
		end
	endtask : define
	task automatic query(mwc_cmd_t c);
		string exp = answer_for(c);
		@(negedge clk_i);
		rx = "";
		cmd_valid_i = 1'b1;
		cmd_code_i = c;
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		repeat (2'($random(seed))) @(negedge clk_i);
		talk_en = 1'b1;
		for (int i = 0; i < 300 && rx.len() < exp.len(); i++)
			@(negedge clk_i);
		talk_en = 1'b0;
		@(negedge clk_i);
		talk_en = 1'b1;
		repeat (8) @(negedge clk_i);
		talk_en = 1'b0;
		cmp("answer", exp, rx);
		if (c == CMD_PURGE_WORDS)
		begin
			names.delete();
			cmds.delete();
		end
	endtask : query
	task automatic invoke(int w, string opts[$], string exp, logic err);
		@(negedge clk_i);
		ex = "";
		inv_start_i = 1'b1;
		inv_word_i = 6'(w);
		@(negedge clk_i);
		inv_start_i = 1'b0;
		foreach (opts[i])
		begin
			for (int k = 0; k < opts[i].len(); k++)
			begin
				opt_valid_i = 1'b1;
				opt_byte_i = opts[i][k];
				@(negedge clk_i);
			end
			opt_valid_i = 1'b0;
			opt_next_i = i < opts.size() - 1;
			opt_end_i = !opt_next_i;
			@(negedge clk_i);
			opt_next_i = 1'b0;
			opt_end_i = 1'b0;
		end
		for (int i = 0; i < 300 && ex.len() < exp.len(); i++)
			@(negedge clk_i);
		repeat (30) @(negedge clk_i);
		cmp("executed", exp, ex);
		cmp_bit("option error", err, macro_err_o);
		err_clear_i = 1'b1;
		@(negedge clk_i);
		err_clear_i = 1'b0;
	endtask : invoke
	task automatic tally_and_finish();
		if (errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (2) @(negedge clk_i);
		reset_i = 1'b0;
		// Empty store answers with the terminator alone
		query(CMD_WORD_LIST);
		query(QRY_NAME_LIST);
		define(rstr(NAME_MAX), "R$X");
		define(rstr(1 + $unsigned($random(seed)) % 8), "V$,$,$,5X");
		define(rstr(NAME_MAX + 1), "F0X");
		define(rstr(3), "F1R0X");
		d = string'(8'h30 + 8'($unsigned($random(seed)) % 10));
		invoke(0, '{d}, {"R", d, "X|"}, 1'b0);
		invoke(1, '{"1", "10", d}, {"V1,10,", d, ",5X|"}, 1'b0);
		invoke(1, '{"1"}, "", 1'b1);
		// Index past the stored words is refused as an error
		invoke(5, '{"1"}, "", 1'b1);
		slow = 1'b1;
		query(QRY_TRANSLATE_STATE);
		slow = 1'b0;
		xlat_enabled_i = 1'b1;
		term_byte_i = 8'h0d;
		// Every code in turn; purge comes before the final word list
		for (int c = 6; c >= 0; c--)
			query(mwc_cmd_t'(c));
		// Both bus clears erase the store
		for (int k = 1; k < 3; k++)
		begin
			define(rstr(4), "G2S2X");
			{sdc_i, dcl_i} = 2'(k);
			@(negedge clk_i);
			{sdc_i, dcl_i} = 2'b00;
			names.delete();
			cmds.delete();
			query(QRY_NAME_LIST);
		end
		tally_and_finish();
	end
endmodule : tb
